//--- aisw_device.sv
// aisw_device.sv: slave end of the two-wire link with bus-lock watchdog
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - data line steady while clock high
// - first byte: seven-bit address plus direction
// - acknowledge own address, else wait for start
// - write: register address then one data byte
// - register address uses upper seven bits
// - read: address, register, repeated start, read
// - master ack continues, nack ends, release line
// - register address advances after each sent byte
// - read starts at last written address, else zero
// - watchdog frees bus held by this device
// - watchdog off, or 1 ms, or 10 ms
// - master waits after writes, longer in low power
// - master waits after every read
// - back-to-back multi-axis reads supported
// - low power only lengthens the master wait after writes
// - protocol select chooses this interface when high
// - select input driven, picks address bit
// - default address 000 1011, lsb flips
// - works at standard and fast speeds
module aisw_device
  import aisw_pkg::*;
#(
  parameter int WD_SHORT_CYCLES = WD_SHORT_CYCLES_DEF,
  parameter int WD_LONG_CYCLES = WD_LONG_CYCLES_DEF
)
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  aisw_if.device bus,
  input wire logic protocol_select_pin_in,
  input wire logic protocol_select_float_in,
  input wire logic addr_select_n_in,
  input wire logic watchdog_enable_in,
  input wire logic watchdog_period_select_in,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [6:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  input wire logic [7:0] reg_rdata_in,
  output logic wd_trip_out
);

  localparam int WD_W = $clog2(WD_LONG_CYCLES + 1);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [4:0] meta_reg;
  logic [4:0] sync_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic scl_s;
  logic sda_s;
  logic i2c_on;
  logic [6:0] own_addr;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      meta_reg <= 5'h1b;
      sync_reg <= 5'h1b;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else if (clk_en_in)
    begin
      meta_reg <= {addr_select_n_in, protocol_select_float_in,
        protocol_select_pin_in, bus.sda, bus.scl};
      sync_reg <= meta_reg;
      scl_prev_reg <= sync_reg[0];
      sda_prev_reg <= sync_reg[1];
    end
  end

  assign scl_s = sync_reg[0];
  assign sda_s = sync_reg[1];
  // a floating select pin means the standalone mode, so the link stays off
  assign i2c_on = sync_reg[2] && !sync_reg[3];
  assign own_addr = DEV_ADDR_BASE ^ {6'h00, sync_reg[4]};
  assign scl_rise = scl_s && !scl_prev_reg;
  assign scl_fall = !scl_s && scl_prev_reg;
  // edges seen on synced copies; clk at 100 MHz oversamples fast mode well
  assign start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
  assign stop_det = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

  // ---------------------------------------------------------------
  // bus-lock watchdog
  // ---------------------------------------------------------------
  logic [WD_W-1:0] wd_cnt_reg;
  logic [WD_W-1:0] wd_limit;
  logic wd_trip;
  logic oe_reg;

  assign wd_limit = watchdog_period_select_in ? WD_W'(WD_LONG_CYCLES)
                                              : WD_W'(WD_SHORT_CYCLES);
  // lock = we hold data low and the clock never moves for a whole period
  assign wd_trip = watchdog_enable_in && (wd_cnt_reg >= wd_limit);

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      wd_cnt_reg <= '0;
      wd_trip_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      wd_trip_out <= wd_trip;
      if (!watchdog_enable_in || !oe_reg || scl_rise || scl_fall || wd_trip)
        wd_cnt_reg <= '0;
      else
        wd_cnt_reg <= wd_cnt_reg + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // protocol engine
  // ---------------------------------------------------------------
  aisw_dev_state_e state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic rw_reg;
  logic ack_ok_reg;
  logic [6:0] ptr_reg;
  logic [6:0] cur_reg;
  logic fetch_reg;
  logic load_reg;
  logic wr_reg;
  logic [7:0] wdata_reg;

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      load_reg <= 1'b0;
    else if (clk_en_in)
      load_reg <= fetch_reg;
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_reg <= DS_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      oe_reg <= 1'b0;
      rw_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
      ptr_reg <= REG_PTR_RESET;
      cur_reg <= REG_PTR_RESET;
      fetch_reg <= 1'b0;
      wr_reg <= 1'b0;
      wdata_reg <= 8'h00;
    end
    else if (clk_en_in)
    begin
      fetch_reg <= 1'b0;
      wr_reg <= 1'b0;
      if (!i2c_on || wd_trip)
      begin
        state_reg <= DS_IDLE;
        oe_reg <= 1'b0;
      end
      else if (start_det)
      begin
        state_reg <= DS_ADDR;
        cnt_reg <= 4'h0;
        oe_reg <= 1'b0;
      end
      else if (stop_det)
      begin
        state_reg <= DS_IDLE;
        oe_reg <= 1'b0;
      end
      else if (load_reg)
      begin
        tx_reg <= reg_rdata_in;
        oe_reg <= !reg_rdata_in[7];
        cnt_reg <= 4'h0;
      end
      else if (scl_rise)
      begin
        if (state_reg == DS_ADDR || state_reg == DS_REG ||
            state_reg == DS_DATA)
        begin
          shift_reg <= {shift_reg[6:0], sda_s};
          cnt_reg <= cnt_reg + 1'b1;
        end
        else if (state_reg == DS_TX)
          cnt_reg <= cnt_reg + 1'b1;
        else if (state_reg == DS_MACK)
          ack_ok_reg <= !sda_s;
      end
      else if (scl_fall)
      begin
        // every drive change happens with the clock low
        unique case (state_reg)
          DS_ADDR:
          begin
            if (cnt_reg == ACK_BIT_IDX)
            begin
              if (shift_reg[7:1] == own_addr)
              begin
                state_reg <= DS_ADDR_ACK;
                oe_reg <= 1'b1;
                rw_reg <= shift_reg[0];
                if (shift_reg[0])
                  cur_reg <= ptr_reg;
              end
              else
                state_reg <= DS_IDLE;
            end
          end
          DS_ADDR_ACK:
          begin
            oe_reg <= 1'b0;
            cnt_reg <= 4'h0;
            if (rw_reg)
            begin
              state_reg <= DS_TX;
              fetch_reg <= 1'b1;
            end
            else
              state_reg <= DS_REG;
          end
          DS_REG:
          begin
            if (cnt_reg == ACK_BIT_IDX)
            begin
              ptr_reg <= shift_reg[7:1];
              cur_reg <= shift_reg[7:1];
              state_reg <= DS_REG_ACK;
              oe_reg <= 1'b1;
            end
          end
          DS_REG_ACK:
          begin
            oe_reg <= 1'b0;
            cnt_reg <= 4'h0;
            state_reg <= DS_DATA;
          end
          DS_DATA:
          begin
            if (cnt_reg == ACK_BIT_IDX)
            begin
              wr_reg <= 1'b1;
              wdata_reg <= shift_reg;
              state_reg <= DS_DATA_ACK;
              oe_reg <= 1'b1;
            end
          end
          DS_DATA_ACK:
          begin
            oe_reg <= 1'b0;
            // further bytes of a write are not taken
            state_reg <= DS_DONE;
          end
          DS_TX:
          begin
            if (cnt_reg == ACK_BIT_IDX)
            begin
              oe_reg <= 1'b0;
              state_reg <= DS_MACK;
              cur_reg <= cur_reg + 1'b1;
            end
            else
            begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              oe_reg <= !tx_reg[6];
            end
          end
          DS_MACK:
          begin
            cnt_reg <= 4'h0;
            if (ack_ok_reg)
            begin
              state_reg <= DS_TX;
              fetch_reg <= 1'b1;
            end
            else
              state_reg <= DS_DONE;
          end
          DS_IDLE, DS_DONE:
          begin
            oe_reg <= 1'b0;
          end
          default:
          begin
            state_reg <= DS_IDLE;
            oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = oe_reg;
  assign reg_wr_out = wr_reg;
  assign reg_rd_out = fetch_reg;
  assign reg_addr_out = cur_reg;
  assign reg_wdata_out = wdata_reg;

endmodule : aisw_device
`default_nettype wire

//--- aisw_host.sv
// aisw_host.sv: controller end of the two-wire link with register port
`timescale 1ns/1ps
`default_nettype none
module aisw_host
  import aisw_pkg::*;
#(
  parameter int QUARTER_CYCLES = QUARTER_CYCLES_DEF,
  parameter int GAP_WR_CYCLES = GAP_WR_CYCLES_DEF,
  parameter int GAP_WR_LP_CYCLES = GAP_WR_LP_CYCLES_DEF,
  parameter int GAP_RD_CYCLES = GAP_RD_CYCLES_DEF
)
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  aisw_if.host bus,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out
);

  localparam int QW = $clog2(QUARTER_CYCLES + 1);
  localparam int GW = $clog2(GAP_WR_LP_CYCLES + 1);

  // ---------------------------------------------------------------
  // registers and pin sync
  // ---------------------------------------------------------------
  aisw_host_state_e state_reg;
  logic lp_reg;
  logic [6:0] slave_reg;
  logic [6:0] regaddr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] count_reg;
  logic nack_reg;
  logic rxv_reg;
  logic [7:0] rx_reg;
  logic [1:0] sda_sync_reg;
  logic go_wr;
  logic go_rd;
  logic rx_set;

  assign go_wr = reg_wr_in && reg_addr_in == HREG_CMD &&
    reg_wdata_in[CMD_WRITE_BIT] && state_reg == HS_IDLE;
  assign go_rd = reg_wr_in && reg_addr_in == HREG_CMD &&
    !reg_wdata_in[CMD_WRITE_BIT] && reg_wdata_in[CMD_READ_BIT] &&
    state_reg == HS_IDLE;

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      lp_reg <= 1'b0;
      slave_reg <= DEV_ADDR_BASE;
      regaddr_reg <= REG_PTR_RESET;
      wdata_reg <= 8'h00;
      count_reg <= COUNT_RESET;
      rxv_reg <= 1'b0;
      reg_rdata_out <= 32'h0000_0000;
      sda_sync_reg <= 2'h3;
    end
    else if (clk_en_in)
    begin
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
      if (reg_wr_in && reg_addr_in == HREG_CMD)
        lp_reg <= reg_wdata_in[CMD_LP_BIT];
      if (reg_wr_in && reg_addr_in == HREG_ADDR)
      begin
        slave_reg <= reg_wdata_in[ADDR_SLAVE_LSB +: 7];
        regaddr_reg <= reg_wdata_in[ADDR_REG_LSB +: 7];
      end
      if (reg_wr_in && reg_addr_in == HREG_DATA)
      begin
        wdata_reg <= reg_wdata_in[DATA_WDATA_LSB +: 8];
        count_reg <= reg_wdata_in[DATA_COUNT_LSB +: 8];
      end
      // a new byte wins over the clear by a read of the receive register
      if (rx_set)
        rxv_reg <= 1'b1;
      else if (reg_rd_in && reg_addr_in == HREG_RX)
        rxv_reg <= 1'b0;
      reg_rdata_out <= 32'h0000_0000;
      if (reg_rd_in)
      begin
        unique case (reg_addr_in)
          HREG_CMD: reg_rdata_out[CMD_LP_BIT] <= lp_reg;
          HREG_ADDR: reg_rdata_out <= {17'h00000, regaddr_reg, 1'b0, slave_reg};
          HREG_DATA: reg_rdata_out <= {16'h0000, count_reg, wdata_reg};
          HREG_STATUS: reg_rdata_out <= {16'h0000, rx_reg, 5'h00, rxv_reg,
            nack_reg, state_reg != HS_IDLE};
          HREG_RX: reg_rdata_out <= {24'h000000, rx_reg};
          default: reg_rdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // bit sequencer
  // ---------------------------------------------------------------
  logic [QW-1:0] qcnt_reg;
  logic [1:0] q_reg;
  logic [3:0] bit_reg;
  logic [1:0] step_reg;
  logic is_rd_reg;
  logic [7:0] left_reg;
  logic [7:0] sh_reg;
  logic ack_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  logic [GW-1:0] gap_reg;
  logic tick;
  logic sym_end;

  assign tick = qcnt_reg == QW'(QUARTER_CYCLES - 1);
  assign sym_end = tick && q_reg == Q_LAST;
  assign rx_set = sym_end && state_reg == HS_BYTE && step_reg == 2'h3 &&
    bit_reg == ACK_BIT_IDX;

  // address byte of step 0 is always a write, step 2 is the read address on reads, else the data byte
  function automatic logic [7:0] byte_for(input logic [1:0] step,
    input logic [6:0] sl, input logic [6:0] ra, input logic [7:0] wd,
    input logic rd);
    unique case (step)
      2'h0: byte_for = {sl, 1'b0};
      2'h1: byte_for = {ra, 1'b0};
      2'h2: byte_for = rd ? {sl, 1'b1} : wd;
      default: byte_for = 8'hff;
    endcase
  endfunction : byte_for

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_reg <= HS_IDLE;
      qcnt_reg <= '0;
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
      step_reg <= 2'h0;
      is_rd_reg <= 1'b0;
      left_reg <= 8'h00;
      sh_reg <= 8'h00;
      ack_reg <= 1'b1;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      gap_reg <= '0;
      nack_reg <= 1'b0;
      rx_reg <= 8'h00;
    end
    else if (clk_en_in)
    begin
      qcnt_reg <= (state_reg == HS_IDLE || tick) ? '0 : qcnt_reg + 1'b1;
      if (tick)
        q_reg <= q_reg + 1'b1;
      unique case (state_reg)
        HS_IDLE:
        begin
          q_reg <= 2'h0;
          if (go_wr || go_rd)
          begin
            state_reg <= HS_START;
            is_rd_reg <= go_rd;
            step_reg <= 2'h0;
            left_reg <= count_reg;
            nack_reg <= 1'b0;
          end
        end
        HS_START:
        begin
          if (tick && q_reg == 2'h0)
            scl_oe_reg <= 1'b0;
          if (tick && q_reg == 2'h1)
            sda_oe_reg <= 1'b1;
          if (sym_end)
          begin
            scl_oe_reg <= 1'b1;
            state_reg <= HS_BYTE;
            bit_reg <= 4'h0;
            sh_reg <= byte_for(step_reg, slave_reg, regaddr_reg, wdata_reg,
              is_rd_reg);
          end
          else if (q_reg == 2'h0)
            sda_oe_reg <= 1'b0;
        end
        HS_BYTE:
        begin
          // data changes only in quarter 0, with the clock held low
          if (q_reg == 2'h0 && !tick)
          begin
            if (bit_reg == ACK_BIT_IDX)
              sda_oe_reg <= step_reg == 2'h3 && left_reg != 8'h01;
            else
              sda_oe_reg <= step_reg != 2'h3 && !sh_reg[7];
          end
          if (tick && q_reg == 2'h0)
            scl_oe_reg <= 1'b0;
          if (tick && q_reg == 2'h2)
          begin
            if (bit_reg == ACK_BIT_IDX)
              ack_reg <= sda_sync_reg[1];
            else
              sh_reg <= {sh_reg[6:0], sda_sync_reg[1]};
          end
          if (sym_end)
          begin
            scl_oe_reg <= 1'b1;
            bit_reg <= bit_reg + 1'b1;
            if (bit_reg == ACK_BIT_IDX)
            begin
              bit_reg <= 4'h0;
              sh_reg <= byte_for(step_reg + 1'b1, slave_reg, regaddr_reg,
                wdata_reg, is_rd_reg);
              if (step_reg != 2'h3 && ack_reg)
              begin
                nack_reg <= 1'b1;
                state_reg <= HS_STOP;
              end
              else if (step_reg == 2'h3)
              begin
                rx_reg <= sh_reg;
                left_reg <= left_reg - 1'b1;
                if (left_reg == 8'h01)
                  state_reg <= HS_STOP;
              end
              else if (step_reg == 2'h1 && is_rd_reg)
              begin
                step_reg <= 2'h2;
                state_reg <= HS_START;
              end
              else if (step_reg == 2'h2 && !is_rd_reg)
                state_reg <= HS_STOP;
              else
                step_reg <= step_reg + 1'b1;
            end
          end
        end
        HS_STOP:
        begin
          if (q_reg == 2'h0 && !tick)
            sda_oe_reg <= 1'b1;
          if (tick && q_reg == 2'h0)
            scl_oe_reg <= 1'b0;
          if (tick && q_reg == 2'h2)
            sda_oe_reg <= 1'b0;
          if (sym_end)
          begin
            state_reg <= HS_GAP;
            if (!is_rd_reg)
              gap_reg <= lp_reg ? GW'(GAP_WR_LP_CYCLES)
                                : GW'(GAP_WR_CYCLES);
            else
              gap_reg <= GW'(GAP_RD_CYCLES);
          end
        end
        HS_GAP:
        begin
          if (gap_reg == '0)
            state_reg <= HS_IDLE;
          else
            gap_reg <= gap_reg - 1'b1;
        end
        default: state_reg <= HS_IDLE;
      endcase
    end
  end

  assign bus.host_scl_o = 1'b0;
  assign bus.host_scl_oe = scl_oe_reg;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = sda_oe_reg;

endmodule : aisw_host
`default_nettype wire

//--- aisw_if.sv
// aisw_if.sv: open-drain two-wire link joining controller and device
`timescale 1ns/1ps
`default_nettype none
interface aisw_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // wired-and with pull-ups: low whenever an enabled driver sends zero
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
    output host_sda_o, output host_sda_oe);
endinterface : aisw_if
`default_nettype wire

//--- aisw_link_chk.sv
// aisw_link_chk.sv: wire-level checks on the two-wire link
`timescale 1ns/1ps
`default_nettype none
module aisw_link_chk #(
  parameter int GAP_MIN = aisw_pkg::GAP_RD_CYCLES_DEF
)
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe
);
  // ------------------------------------------------------------
  // link checks
  // ------------------------------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic [15:0] gap_reg;

  // saturates so a start right after reset is never flagged
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      gap_reg <= 16'hffff;
    else if (scl && $rose(sda))
      gap_reg <= 16'h0000;
    else if (gap_reg != 16'hffff)
      gap_reg <= gap_reg + 16'h0001;
  end

  property p_dev_steady;
    scl && $past(scl) |-> $stable(dev_sda_oe);
  endproperty
  a_dev_steady: assert property (p_dev_steady)
    else $error("device data moved while clock high");
  property p_one_driver;
    dev_sda_oe && scl |-> !host_sda_oe;
  endproperty
  a_one_driver: assert property (p_one_driver)
    else $error("both ends drive data in clock high");
  property p_dev_on_low;
    $rose(dev_sda_oe) |-> !scl;
  endproperty
  a_dev_on_low: assert property (p_dev_on_low)
    else $error("device took data line in clock high");
  property p_dev_off_low;
    $fell(dev_sda_oe) |-> !scl;
  endproperty
  a_dev_off_low: assert property (p_dev_off_low)
    else $error("device let go in clock high");
  property p_ack_delay;
    $rose(dev_sda_oe) |-> !$past(scl, 2) && $past(scl, 7);
  endproperty
  a_ack_delay: assert property (p_ack_delay)
    else $error("device drive not tied to clock fall");
  property p_host_edges;
    scl && $past(scl) && $changed(sda) |-> !$past(dev_sda_oe);
  endproperty
  a_host_edges: assert property (p_host_edges)
    else $error("data edge in clock high from device");
  property p_quiet_reset;
    $fell(reset_in) |-> !dev_sda_oe && !host_sda_oe && !host_scl_oe;
  endproperty
  a_quiet_reset: assert property (p_quiet_reset)
    else $error("link not released after reset");
  property p_gap;
    scl && $fell(sda) |-> gap_reg >= GAP_MIN;
  endproperty
  a_gap: assert property (p_gap)
    else $error("start too soon after stop");
  c_start: cover property (scl && $fell(sda));
  c_stop: cover property (scl && $rose(sda));
  c_dev: cover property ($rose(dev_sda_oe));
endmodule : aisw_link_chk
`default_nettype wire

//--- aisw_pkg.sv
// aisw_pkg.sv: shared constants and state types of the two-wire link
package aisw_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int WD_SHORT_NS = 1000000;
  localparam int WD_LONG_NS = 10000000;
  localparam int WD_SHORT_CYCLES_DEF = WD_SHORT_NS / CLK_PERIOD_NS;
  localparam int WD_LONG_CYCLES_DEF = WD_LONG_NS / CLK_PERIOD_NS;
  localparam int GAP_WR_NS = 3000;
  localparam int GAP_WR_LP_NS = 300000;
  localparam int GAP_RD_NS = 2000;
  // spacing must be strictly longer than printed, hence the extra cycle
  localparam int GAP_WR_CYCLES_DEF = GAP_WR_NS / CLK_PERIOD_NS + 1;
  localparam int GAP_WR_LP_CYCLES_DEF = GAP_WR_LP_NS / CLK_PERIOD_NS + 1;
  localparam int GAP_RD_CYCLES_DEF = GAP_RD_NS / CLK_PERIOD_NS + 1;
  localparam int SCL_STD_HZ = 100000;
  localparam int QUARTER_CYCLES_DEF =
    1000000000 / (SCL_STD_HZ * 4 * CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // link framing
  // ---------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR_BASE = 7'h0b;
  localparam logic [6:0] REG_PTR_RESET = 7'h00;
  localparam logic [3:0] ACK_BIT_IDX = 4'h8;
  localparam logic [1:0] Q_LAST = 2'h3;

  // ---------------------------------------------------------------
  // controller registers
  // ---------------------------------------------------------------
  localparam logic [7:0] HREG_CMD = 8'h00;
  localparam logic [7:0] HREG_ADDR = 8'h04;
  localparam logic [7:0] HREG_DATA = 8'h08;
  localparam logic [7:0] HREG_STATUS = 8'h0c;
  localparam logic [7:0] HREG_RX = 8'h10;
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int CMD_LP_BIT = 2;
  localparam int ADDR_SLAVE_LSB = 0;
  localparam int ADDR_REG_LSB = 8;
  localparam int DATA_WDATA_LSB = 0;
  localparam int DATA_COUNT_LSB = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam int STAT_RXV_BIT = 2;
  localparam int STAT_RX_LSB = 8;
  localparam logic [7:0] COUNT_RESET = 8'h01;

  typedef enum logic [3:0] {
    DS_IDLE = 4'h0,
    DS_ADDR = 4'h1,
    DS_ADDR_ACK = 4'h2,
    DS_REG = 4'h3,
    DS_REG_ACK = 4'h4,
    DS_DATA = 4'h5,
    DS_DATA_ACK = 4'h6,
    DS_TX = 4'h7,
    DS_MACK = 4'h8,
    DS_DONE = 4'h9
  } aisw_dev_state_e;

  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_START = 3'h1,
    HS_BYTE = 3'h2,
    HS_STOP = 3'h3,
    HS_GAP = 3'h4
  } aisw_host_state_e;

endpackage : aisw_pkg

//--- testbench.sv
// testbench.sv: both link ends driven through the controller registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import aisw_pkg::*;
  typedef struct packed {
    logic ps; logic sel_n; logic [6:0] sl; logic [6:0] ra;
    logic [7:0] d; logic ack;
  } aisw_row_s;
  // ------------------------------------------------------------
  // bench
  // ------------------------------------------------------------
  logic clk_in = 1'h0, reset_in = 1'h1, hen = 1'h1, ps = 1'h1, pf = 1'h0;
  logic sel_n = 1'h0, wd_en = 1'h0, wd_sel = 1'h0, wr = 1'h0, rd = 1'h0;
  logic [7:0] ha = 8'h00, dd, drq = 8'h00;
  logic [31:0] hd = 32'h0, hq, got;
  logic dwr, drd, trip;
  logic [6:0] da;
  logic [14:0] lw;
  logic [6:0] rq[$];
  int miscompares = 0, tests_run = 0, wcnt = 0, n, k, lim;
  aisw_row_s rows[5] = '{
    '{1'h1, 1'h0, 7'h0b, 7'h0e, 8'hd5, 1'h1},
    '{1'h1, 1'h0, 7'h0c, 7'h03, 8'h11, 1'h0},
    '{1'h1, 1'h1, 7'h0a, 7'h7f, 8'h00, 1'h1},
    '{1'h1, 1'h1, 7'h0b, 7'h01, 8'hff, 1'h0},
    '{1'h0, 1'h0, 7'h0b, 7'h02, 8'h5a, 1'h0}};
  aisw_if i_aisw_if ();
  aisw_host #(.QUARTER_CYCLES(20)) i_aisw_host (
    .clk_in(clk_in), .reset_in(reset_in), .clk_en_in(hen),
    .bus(i_aisw_if.host), .reg_addr_in(ha), .reg_wdata_in(hd),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(hq));
  aisw_device #(.WD_SHORT_CYCLES(200), .WD_LONG_CYCLES(2000)) i_aisw_device (
    .clk_in(clk_in), .reset_in(reset_in), .clk_en_in(1'h1),
    .bus(i_aisw_if.device), .protocol_select_pin_in(ps),
    .protocol_select_float_in(pf), .addr_select_n_in(sel_n),
    .watchdog_enable_in(wd_en), .watchdog_period_select_in(wd_sel),
    .reg_wr_out(dwr), .reg_rd_out(drd), .reg_addr_out(da),
    .reg_wdata_out(dd), .reg_rdata_in(drq), .wd_trip_out(trip));
  aisw_link_chk i_aisw_link_chk (.clk_in(clk_in),
    .reset_in(reset_in), .scl(i_aisw_if.scl), .sda(i_aisw_if.sda),
    .host_scl_oe(i_aisw_if.host_scl_oe),
    .host_sda_oe(i_aisw_if.host_sda_oe),
    .dev_sda_oe(i_aisw_if.dev_sda_oe));
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    drq <= {1'h1, da} ^ 8'h3c;
    if (dwr) begin wcnt++; lw <= {da, dd}; end
    if (drd) rq.push_back(da);
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin miscompares++; $display("BAD %0t %h/%h", $time, s, e); end
  endtask : chk
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in); ha <= a; hd <= d; wr <= 1'h1;
    @(posedge clk_in); wr <= 1'h0;
  endtask : wreg
  task rreg(input logic [7:0] a);
    @(posedge clk_in); ha <= a; rd <= 1'h1;
    @(posedge clk_in); rd <= 1'h0;
    #1 got = hq;
  endtask : rreg
  task go(input logic [31:0] c);
    wreg(HREG_CMD, c); n = 0;
    do begin rreg(HREG_STATUS); n++; end
    while (got[STAT_BUSY_BIT] !== 1'h0 && n < 4000);
    chk(n < 4000, 1);
  endtask : go
  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (3) @(posedge clk_in);
    reset_in <= 1'h0;
    foreach (rows[i])
    begin
      @(posedge clk_in); ps <= rows[i].ps; sel_n <= rows[i].sel_n;
      repeat (4) @(posedge clk_in);
      k = wcnt;
      wreg(HREG_ADDR, {17'h0, rows[i].ra, 1'h0, rows[i].sl});
      wreg(HREG_DATA, {16'h0, 8'h01, rows[i].d});
      go(32'h1);
      chk(got[STAT_NACK_BIT], !rows[i].ack);
      chk(wcnt - k, rows[i].ack);
      if (rows[i].ack) chk(lw, {rows[i].ra, rows[i].d});
    end
    @(posedge clk_in); ps <= 1'h1; sel_n <= 1'h0; pf <= 1'h1;
    repeat (4) @(posedge clk_in);
    go(32'h1); chk(got[STAT_NACK_BIT], 1);
    @(posedge clk_in); pf <= 1'h0;
    repeat (4) @(posedge clk_in);
    wreg(HREG_ADDR, 32'h0000100b);
    wreg(HREG_DATA, 32'h00000300);
    rq.delete(); go(32'h2);
    chk(rq.size(), 3);
    foreach (rq[i]) chk(rq[i], 7'h10 + i);
    rreg(HREG_RX); chk(got[7:0], 8'h92 ^ 8'h3c);
    wreg(HREG_DATA, 32'h00000100);
    rq.delete(); go(32'h2);
    chk(rq[0], 7'h10);
    for (int p = 0; p < 2; p++)
    begin
      @(posedge clk_in); wd_en <= 1'h1; wd_sel <= p[0];
      lim = p ? 2000 : 200;
      wreg(HREG_CMD, 32'h1); n = 0;
      while (i_aisw_if.dev_sda_oe !== 1'h1 && n < 3000)
        begin @(negedge clk_in); n++; end
      @(posedge clk_in); hen <= 1'h0; n = 0;
      // host frozen mid-ack: only the watchdog can free the line
      while (trip !== 1'h1 && n < 3000) begin @(negedge clk_in); n++; end
      chk(n >= lim - 8 && n <= lim + 8, 1);
      @(negedge clk_in); chk(i_aisw_if.dev_sda_oe, 0);
      @(posedge clk_in); reset_in <= 1'h1; hen <= 1'h1;
      repeat (3) @(posedge clk_in);
      reset_in <= 1'h0;
    end
    rreg(HREG_ADDR); chk(got, 32'h0000000b);
    rreg(HREG_STATUS); chk(got, 32'h0);
    rreg(8'h14); chk(got, 32'h0);
    end_of_test();
  end
  initial
  begin
    #1000000;
    miscompares++;
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
